// ---- core/radio_task_regs.vh ----
// register map, field positions and reset values of the radio task/event bank
`ifndef RADIO_TASK_REGS_VH
`define RADIO_TASK_REGS_VH
// address and data widths
`define ADDR_W 12
`define DATA_W 32
// task registers, write-only triggers
`define OFF_TASK_TX_ENABLE 12'h000
`define OFF_TASK_RX_ENABLE 12'h004
`define OFF_TASK_RADIO_START 12'h008
`define OFF_TASK_RADIO_STOP 12'h00c
`define OFF_TASK_RADIO_DISABLE 12'h010
`define OFF_TASK_STRENGTH_SAMPLE_START 12'h014
`define OFF_TASK_STRENGTH_SAMPLE_STOP 12'h018
`define OFF_TASK_BIT_COUNTER_START 12'h01c
`define OFF_TASK_BIT_COUNTER_STOP 12'h020
// event registers, read/write
`define OFF_EVENT_RAMPED_UP 12'h100
`define OFF_EVENT_ADDRESS_DONE 12'h104
// status, interrupt and capture registers
`define OFF_RADIO_STATUS 12'h3e8
`define OFF_BIT_COUNT 12'h3ec
`define OFF_STRENGTH_SAMPLE 12'h3f0
`define OFF_INT_STATUS 12'h3f4
`define OFF_INT_MASK 12'h3f8
// field positions
`define TRIGGER_BIT 0
`define EVENT_BIT 0
`define EV_RAMPED_UP 0
`define EV_ADDRESS_DONE 1
`define NUM_EVENTS 2
`define STATE_W 3
`define ST_STATE_LSB 0
`define ST_STRENGTH_BUSY 3
`define ST_BIT_COUNTER_RUN 4
// widths and reset values
`define SAMPLE_W 7
`define BITCNT_W 32
`define RESET_WORD 32'h00000000
`define RESET_SAMPLE 7'h00
`define RESET_BITCNT 32'h00000000
`define RESET_EVENTS 2'h0
`endif

// ---- core/pin_sync3.v ----
// three-stage synchroniser with agreement filter and rise pulse
`timescale 1ns/1ps
module pin_sync3 (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire pin_in,
  output reg level_q,
  output reg rise_q
);
  reg s1_q; // first stage, read only by s2
  reg s2_q; // second stage
  reg s3_q; // third stage

  // shift chain; level moves only when stages 2 and 3 agree
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_q <= 1'b0;
      rise_q <= 1'b0;
    end else if (ce) begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      rise_q <= 1'b0;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
        // one pulse per agreed low-to-high change
        rise_q <= s3_q & ~level_q;
      end
    end
  end
endmodule

// ---- core/event_flag.v ----
// sticky event bit, hardware set wins over a software write
`timescale 1ns/1ps
module event_flag (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire hw_set,
  input wire sw_write,
  input wire sw_value,
  output reg flag_q
);
  // set has priority so a simultaneous event is never lost
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 1'b0;
    end else if (ce) begin
      if (hw_set) begin
        flag_q <= 1'b1;
      end else if (sw_write) begin
        flag_q <= sw_value;
      end
    end
  end
endmodule

// ---- core/radio_task_event_strobes.v ----
// task strobes, event flags and apb slave of the radio control bank
//
// Behaviour
// - writing 1 to tx task enables transmit
// - writing trigger to rx task enables receive
// - strength start captures exactly one sample
// - strength stop ends ongoing measurement
// - bit counter start task starts counter
// - bit counter stop task halts counter
// - ramped-up event set when radio ready
// - address event set on address done
`timescale 1ns/1ps
`include "radio_task_regs.vh"
module radio_task_event_strobes (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`ADDR_W-1:0] paddr,
  input wire [`DATA_W-1:0] pwdata,
  output reg [`DATA_W-1:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire ramped_up_in,
  input wire address_done_in,
  input wire strength_valid,
  input wire [`SAMPLE_W-1:0] strength_value,
  input wire bit_tick,
  output reg tx_enable_pulse,
  output reg rx_enable_pulse,
  output reg radio_start_pulse,
  output reg radio_stop_pulse,
  output reg radio_disable_pulse,
  output reg strength_start_pulse,
  output reg strength_stop_pulse,
  output reg bit_counter_start_pulse,
  output reg bit_counter_stop_pulse,
  output reg irq
);
  // radio state tracker codes
  localparam [`STATE_W-1:0] ST_OFF = 3'h0;
  localparam [`STATE_W-1:0] ST_TX_RAMP = 3'h1;
  localparam [`STATE_W-1:0] ST_RX_RAMP = 3'h2;
  localparam [`STATE_W-1:0] ST_TX_READY = 3'h3;
  localparam [`STATE_W-1:0] ST_RX_READY = 3'h4;
  localparam [`STATE_W-1:0] ST_TX_RUN = 3'h5;
  localparam [`STATE_W-1:0] ST_RX_RUN = 3'h6;

  // address match, used by every write decode below
  function hit;
    input [`ADDR_W-1:0] addr;
    input [`ADDR_W-1:0] off;
    begin
      hit = (addr == off);
    end
  endfunction

  // apb phases
  wire access; // access phase, request held
  wire wr_fire; // write takes effect this edge
  wire trig; // trigger value on write data
  assign access = psel & penable;
  assign wr_fire = access & pready & pwrite;
  assign trig = pwdata[`TRIGGER_BIT];

  // task strobes decoded from a completed write of 1
  wire do_tx_en; // transmit enable
  wire do_rx_en; // receive enable
  wire do_start; // radio start
  wire do_stop; // radio stop
  wire do_disable; // radio disable
  wire do_s_start; // strength sample start
  wire do_s_stop; // strength sample stop
  wire do_bc_start; // bit counter start
  wire do_bc_stop; // bit counter stop
  assign do_tx_en = wr_fire & trig & hit(paddr, `OFF_TASK_TX_ENABLE);
  assign do_rx_en = wr_fire & trig & hit(paddr, `OFF_TASK_RX_ENABLE);
  assign do_start = wr_fire & trig & hit(paddr, `OFF_TASK_RADIO_START);
  assign do_stop = wr_fire & trig & hit(paddr, `OFF_TASK_RADIO_STOP);
  assign do_disable = wr_fire & trig & hit(paddr, `OFF_TASK_RADIO_DISABLE);
  assign do_s_start = wr_fire & trig & hit(paddr, `OFF_TASK_STRENGTH_SAMPLE_START);
  assign do_s_stop = wr_fire & trig & hit(paddr, `OFF_TASK_STRENGTH_SAMPLE_STOP);
  assign do_bc_start = wr_fire & trig & hit(paddr, `OFF_TASK_BIT_COUNTER_START);
  assign do_bc_stop = wr_fire & trig & hit(paddr, `OFF_TASK_BIT_COUNTER_STOP);

  // software writes to the event registers
  wire [`NUM_EVENTS-1:0] ev_write; // write strobe per event
  assign ev_write[`EV_RAMPED_UP] = wr_fire & hit(paddr, `OFF_EVENT_RAMPED_UP);
  assign ev_write[`EV_ADDRESS_DONE] = wr_fire & hit(paddr, `OFF_EVENT_ADDRESS_DONE);

  // radio-side event inputs
  wire [`NUM_EVENTS-1:0] ev_pin; // raw asynchronous levels
  wire [`NUM_EVENTS-1:0] ev_rise; // one-cycle event pulses
  wire [`NUM_EVENTS-1:0] ev_flag; // sticky event register bits
  assign ev_pin[`EV_RAMPED_UP] = ramped_up_in;
  assign ev_pin[`EV_ADDRESS_DONE] = address_done_in;

  // one synchroniser and one sticky flag per event
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_EVENTS; gi = gi + 1) begin : g_event
      pin_sync3 u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .pin_in(ev_pin[gi]),
        .level_q(),
        .rise_q(ev_rise[gi])
      );
      // sticky flag, a radio event sets it
      event_flag u_flag (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .hw_set(ev_rise[gi]),
        .sw_write(ev_write[gi]),
        .sw_value(pwdata[`EVENT_BIT]),
        .flag_q(ev_flag[gi])
      );
    end
  endgenerate

  // task pulses to the radio core, one cycle each while ce is high, held while ce is low
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_enable_pulse <= 1'b0;
      rx_enable_pulse <= 1'b0;
      radio_start_pulse <= 1'b0;
      radio_stop_pulse <= 1'b0;
      radio_disable_pulse <= 1'b0;
      strength_start_pulse <= 1'b0;
      strength_stop_pulse <= 1'b0;
      bit_counter_start_pulse <= 1'b0;
      bit_counter_stop_pulse <= 1'b0;
    end else if (ce) begin
      tx_enable_pulse <= do_tx_en;
      rx_enable_pulse <= do_rx_en;
      radio_start_pulse <= do_start;
      radio_stop_pulse <= do_stop;
      radio_disable_pulse <= do_disable;
      strength_start_pulse <= do_s_start;
      strength_stop_pulse <= do_s_stop;
      bit_counter_start_pulse <= do_bc_start;
      bit_counter_stop_pulse <= do_bc_stop;
    end
  end

  // radio state tracker
  reg [`STATE_W-1:0] state_q; // current state
  reg [`STATE_W-1:0] state_d; // next state

  // next state; disable wins over every other task
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_OFF: begin
        // enable tasks start a ramp-up
        if (do_tx_en) begin
          state_d = ST_TX_RAMP;
        end else if (do_rx_en) begin
          state_d = ST_RX_RAMP;
        end
      end
      ST_TX_RAMP: begin
        // ramp finished
        if (ev_rise[`EV_RAMPED_UP]) begin
          state_d = ST_TX_READY;
        end
      end
      ST_RX_RAMP: begin
        // ramp finished
        if (ev_rise[`EV_RAMPED_UP]) begin
          state_d = ST_RX_READY;
        end
      end
      ST_TX_READY: begin
        // start begins transmit
        if (do_start) begin
          state_d = ST_TX_RUN;
        end
      end
      ST_RX_READY: begin
        // start begins receive
        if (do_start) begin
          state_d = ST_RX_RUN;
        end
      end
      ST_TX_RUN: begin
        // stop returns to ready
        if (do_stop) begin
          state_d = ST_TX_READY;
        end
      end
      ST_RX_RUN: begin
        // stop returns to ready
        if (do_stop) begin
          state_d = ST_RX_READY;
        end
      end
      default: begin
        // unused code recovers to off
        state_d = ST_OFF;
      end
    endcase
    if (do_disable) begin
      state_d = ST_OFF;
    end
  end

  // state register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_OFF;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  // signal strength single-sample capture
  reg strength_busy_q; // measurement in progress
  reg [`SAMPLE_W-1:0] sample_q; // last captured sample

  // busy from start until one sample or a stop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strength_busy_q <= 1'b0;
      sample_q <= `RESET_SAMPLE;
    end else if (ce) begin
      if (do_s_stop) begin
        strength_busy_q <= 1'b0;
      end else if (do_s_start) begin
        strength_busy_q <= 1'b1;
      end else if (strength_busy_q & strength_valid) begin
        // take exactly one sample, then finish
        sample_q <= strength_value;
        strength_busy_q <= 1'b0;
      end
    end
  end

  // on-air bit counter
  reg bc_run_q; // counter running
  reg [`BITCNT_W-1:0] bit_count_q; // bits counted since start

  // start clears and runs, stop freezes the count
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bc_run_q <= 1'b0;
      bit_count_q <= `RESET_BITCNT;
    end else if (ce) begin
      if (do_bc_stop) begin
        bc_run_q <= 1'b0;
      end else if (do_bc_start) begin
        bc_run_q <= 1'b1;
        bit_count_q <= `RESET_BITCNT;
      end else if (bc_run_q & bit_tick) begin
        // count one on-air bit
        bit_count_q <= bit_count_q + 1'b1;
      end
    end
  end

  // interrupt status and mask
  reg [`NUM_EVENTS-1:0] int_status_q; // sticky, write one to clear
  reg [`NUM_EVENTS-1:0] int_mask_q; // one enables the source
  wire int_st_wr; // write to interrupt status
  wire int_mk_wr; // write to interrupt mask
  assign int_st_wr = wr_fire & hit(paddr, `OFF_INT_STATUS);
  assign int_mk_wr = wr_fire & hit(paddr, `OFF_INT_MASK);

  // event sets win over a clear in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status_q <= `RESET_EVENTS;
      int_mask_q <= `RESET_EVENTS;
      irq <= 1'b0;
    end else if (ce) begin
      if (int_st_wr) begin
        int_status_q <= (int_status_q & ~pwdata[`NUM_EVENTS-1:0]) | ev_rise;
      end else begin
        int_status_q <= int_status_q | ev_rise;
      end
      if (int_mk_wr) begin
        int_mask_q <= pwdata[`NUM_EVENTS-1:0];
      end
      // level output follows registered status and mask
      irq <= |(int_status_q & int_mask_q);
    end
  end

  // read data and mapped-address check
  reg [`DATA_W-1:0] rdata_d; // read word for current address
  reg mapped_d; // address belongs to this bank

  // read mux; task registers read zero
  always @* begin
    rdata_d = `RESET_WORD;
    mapped_d = 1'b1;
    case (paddr)
      `OFF_TASK_TX_ENABLE, `OFF_TASK_RX_ENABLE, `OFF_TASK_RADIO_START,
      `OFF_TASK_RADIO_STOP, `OFF_TASK_RADIO_DISABLE,
      `OFF_TASK_STRENGTH_SAMPLE_START, `OFF_TASK_STRENGTH_SAMPLE_STOP,
      `OFF_TASK_BIT_COUNTER_START, `OFF_TASK_BIT_COUNTER_STOP: begin
        // write-only, no readable state
        rdata_d = `RESET_WORD;
      end
      `OFF_EVENT_RAMPED_UP: begin
        // ramped-up flag
        rdata_d[`EVENT_BIT] = ev_flag[`EV_RAMPED_UP];
      end
      `OFF_EVENT_ADDRESS_DONE: begin
        // address flag
        rdata_d[`EVENT_BIT] = ev_flag[`EV_ADDRESS_DONE];
      end
      `OFF_RADIO_STATUS: begin
        // state, strength busy, counter running
        rdata_d[`ST_STATE_LSB +: `STATE_W] = state_q;
        rdata_d[`ST_STRENGTH_BUSY] = strength_busy_q;
        rdata_d[`ST_BIT_COUNTER_RUN] = bc_run_q;
      end
      `OFF_BIT_COUNT: begin
        // counted bits
        rdata_d = bit_count_q;
      end
      `OFF_STRENGTH_SAMPLE: begin
        // last sample, low bits
        rdata_d[`SAMPLE_W-1:0] = sample_q;
      end
      `OFF_INT_STATUS: begin
        // pending sources
        rdata_d[`NUM_EVENTS-1:0] = int_status_q;
      end
      `OFF_INT_MASK: begin
        // enabled sources
        rdata_d[`NUM_EVENTS-1:0] = int_mask_q;
      end
      default: begin
        // unmapped: zero and error
        mapped_d = 1'b0;
      end
    endcase
  end

  // apb answer: one wait state, then ready for one cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `RESET_WORD;
    end else if (ce) begin
      if (access & ~pready) begin
        // first access edge: prepare the answer
        pready <= 1'b1;
        pslverr <= ~mapped_d;
        prdata <= pwrite ? `RESET_WORD : rdata_d;
      end else begin
        // answer done or idle
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= `RESET_WORD;
      end
    end
  end
endmodule

// ---- testbench/radio_task_event_strobes_checker.sv ----
// concurrent checks on the ports of the radio task and event bank
`timescale 1ns/1ps
`include "radio_task_regs.vh"
module radio_task_event_strobes_checker (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`ADDR_W-1:0] paddr,
  input wire [`DATA_W-1:0] pwdata,
  input wire [`DATA_W-1:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire ramped_up_in,
  input wire address_done_in,
  input wire strength_valid,
  input wire [`SAMPLE_W-1:0] strength_value,
  input wire bit_tick,
  input wire tx_enable_pulse,
  input wire rx_enable_pulse,
  input wire radio_start_pulse,
  input wire radio_stop_pulse,
  input wire radio_disable_pulse,
  input wire strength_start_pulse,
  input wire strength_stop_pulse,
  input wire bit_counter_start_pulse,
  input wire bit_counter_stop_pulse,
  input wire irq
);
  // completing writes with trigger bit set or clear
  wire wr_one = psel && penable && pready && ce && pwrite && pwdata[0];
  wire wr_zero = psel && penable && pready && ce && pwrite && !pwdata[0];
  // completing trigger write to the transmit task
  wire tx_go = wr_one && (paddr == `OFF_TASK_TX_ENABLE);
  // any of the three radio control words
  wire ctl_addr = (paddr == `OFF_TASK_RADIO_START) || (paddr == `OFF_TASK_RADIO_STOP) ||
    (paddr == `OFF_TASK_RADIO_DISABLE);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  tx_pulse_a: assert property (tx_go |=> tx_enable_pulse)
    else $error("tx enable strobe missing");
  tx_cause_a: assert property ($rose(tx_enable_pulse) |-> $past(tx_go))
    else $error("tx enable strobe without a write");
  rx_pulse_a: assert property (wr_one && paddr == `OFF_TASK_RX_ENABLE |=> rx_enable_pulse)
    else $error("rx enable strobe missing");
  start_pulse_a: assert property (wr_one && paddr == `OFF_TASK_RADIO_START |=> radio_start_pulse)
    else $error("start strobe missing");
  stop_pulse_a: assert property (wr_one && paddr == `OFF_TASK_RADIO_STOP |=> radio_stop_pulse)
    else $error("stop strobe missing");
  disable_pulse_a: assert property (wr_one && paddr == `OFF_TASK_RADIO_DISABLE |=> radio_disable_pulse)
    else $error("disable strobe missing");
  zero_write_a: assert property (wr_zero && ctl_addr |=>
    !(radio_start_pulse || radio_stop_pulse || radio_disable_pulse)) else $error("strobe on zero write");
  strength_go_a: assert property (wr_one && paddr == `OFF_TASK_STRENGTH_SAMPLE_START |=>
    strength_start_pulse ##1 !strength_start_pulse) else $error("strength start strobe wrong");
  strength_end_a: assert property (wr_one && paddr == `OFF_TASK_STRENGTH_SAMPLE_STOP |=>
    strength_stop_pulse) else $error("strength stop strobe missing");
  count_go_a: assert property (wr_one && paddr == `OFF_TASK_BIT_COUNTER_START |=>
    bit_counter_start_pulse) else $error("counter start strobe missing");
  count_halt_a: assert property (wr_one && paddr == `OFF_TASK_BIT_COUNTER_STOP |=>
    bit_counter_stop_pulse) else $error("counter stop strobe missing");
  // main scenarios reached
  cover property (tx_go);
  cover property ($rose(irq));
  cover property (pready && pslverr);
endmodule

bind radio_task_event_strobes radio_task_event_strobes_checker u_radio_task_event_strobes_checker (
  .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .ramped_up_in, .address_done_in, .strength_valid, .strength_value, .bit_tick, .tx_enable_pulse,
  .rx_enable_pulse, .radio_start_pulse, .radio_stop_pulse, .radio_disable_pulse, .strength_start_pulse,
  .strength_stop_pulse, .bit_counter_start_pulse, .bit_counter_stop_pulse, .irq
);

// ---- testbench/radio_task_event_strobes_test.sv ----
// self-checking bench for the radio task and event bank
`timescale 1ns/1ps
`include "radio_task_regs.vh"
module radio_task_event_strobes_test;
  logic pclk = 1'h0; // 200 MHz clock
  logic presetn = 1'h0; // held low at start
  logic ce = 1'h1; // enabled except while test_freeze drives it low
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0; // apb control
  logic [`ADDR_W-1:0] paddr = 12'h000; // apb address
  logic [`DATA_W-1:0] pwdata = 32'h0; // apb write data
  logic ramped_up_in = 1'h0, address_done_in = 1'h0; // radio event levels
  logic strength_valid = 1'h0, bit_tick = 1'h0; // sample valid, bit tick
  logic [`SAMPLE_W-1:0] strength_value = 7'h00; // sample value
  wire [`DATA_W-1:0] prdata;
  wire pready, pslverr, irq;
  wire tx_enable_pulse, rx_enable_pulse, radio_start_pulse, radio_stop_pulse, radio_disable_pulse;
  wire strength_start_pulse, strength_stop_pulse, bit_counter_start_pulse, bit_counter_stop_pulse;
  // strobes in task word order
  wire [8:0] pulses = {bit_counter_stop_pulse, bit_counter_start_pulse, strength_stop_pulse,
    strength_start_pulse, radio_disable_pulse, radio_stop_pulse, radio_start_pulse, rx_enable_pulse,
    tx_enable_pulse};
  int errors = 0, compares = 0; // mismatch and comparison counts
  logic [31:0] rd; // last read data
  logic err; // last slave error
  radio_task_event_strobes u_radio_task_event_strobes (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .ramped_up_in, .address_done_in, .strength_valid,
    .strength_value, .bit_tick, .tx_enable_pulse, .rx_enable_pulse, .radio_start_pulse, .radio_stop_pulse,
    .radio_disable_pulse, .strength_start_pulse, .strength_stop_pulse, .bit_counter_start_pulse,
    .bit_counter_stop_pulse, .irq);
  // clock generator
  always #2.5 pclk = ~pclk;
  // compare and count
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one apb transfer from the next edge, held until pready
  task apb(input logic w, input logic [`ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1);
    chk("pready wait", 32'h2, n);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // read a word and compare it
  task rd_chk(input string nm, input logic [`ADDR_W-1:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(nm, exp, rd);
    chk("slave error", 32'h0, {31'h0, err});
  endtask
  // bit ticks, one cycle each
  task ticks(input int n);
    repeat (n) begin
      @(posedge pclk);
      bit_tick <= 1'h1;
      @(posedge pclk);
      bit_tick <= 1'h0;
    end
  endtask
  // reset values
  task test_reset;
    rd_chk("ramped event", `OFF_EVENT_RAMPED_UP, 32'h0);
    rd_chk("address event", `OFF_EVENT_ADDRESS_DONE, 32'h0);
    rd_chk("int mask", `OFF_INT_MASK, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
  endtask
  // each word fires only its own strobe; zero writes fire none and task words read zero
  task test_strobes;
    for (int i = 0; i < 9; i++) begin
      apb(1'h1, 12'(i * 4), 32'h0);
      @(posedge pclk);
      chk("zero strobe", 32'h0, {23'h0, pulses});
      apb(1'h1, 12'(i * 4), 32'h1);
      @(posedge pclk);
      chk("strobe", 32'h1 << i, {23'h0, pulses});
      rd_chk("task read", 12'(i * 4), 32'h0);
    end
  endtask
  // radio state walk through ramp, run, stop and disable
  task test_state;
    apb(1'h1, `OFF_TASK_TX_ENABLE, 32'h1);
    rd_chk("tx ramp", `OFF_RADIO_STATUS, 32'h1);
    ramped_up_in <= 1'h1;
    repeat (8) @(posedge pclk);
    rd_chk("tx ready", `OFF_RADIO_STATUS, 32'h3);
    rd_chk("ramped event", `OFF_EVENT_RAMPED_UP, 32'h1);
    chk("masked irq", 32'h0, {31'h0, irq});
    apb(1'h1, `OFF_TASK_RADIO_START, 32'h1);
    rd_chk("tx run", `OFF_RADIO_STATUS, 32'h5);
    apb(1'h1, `OFF_TASK_RADIO_STOP, 32'h1);
    rd_chk("stopped", `OFF_RADIO_STATUS, 32'h3);
    apb(1'h1, `OFF_TASK_RADIO_DISABLE, 32'h1);
    rd_chk("off", `OFF_RADIO_STATUS, 32'h0);
    ramped_up_in <= 1'h0;
    repeat (8) @(posedge pclk);
    apb(1'h1, `OFF_TASK_RX_ENABLE, 32'h1);
    rd_chk("rx ramp", `OFF_RADIO_STATUS, 32'h2);
    ramped_up_in <= 1'h1;
    repeat (8) @(posedge pclk);
    rd_chk("rx ready", `OFF_RADIO_STATUS, 32'h4);
    apb(1'h1, `OFF_TASK_RADIO_START, 32'h1);
    rd_chk("rx run", `OFF_RADIO_STATUS, 32'h6);
    apb(1'h1, `OFF_TASK_RADIO_DISABLE, 32'h1);
    rd_chk("rx off", `OFF_RADIO_STATUS, 32'h0);
  endtask
  // one sample only, and stop drops a pending measurement
  task test_strength;
    apb(1'h1, `OFF_TASK_STRENGTH_SAMPLE_START, 32'h1);
    rd_chk("strength busy", `OFF_RADIO_STATUS, 32'h8);
    @(posedge pclk);
    strength_valid <= 1'h1;
    strength_value <= 7'h2a;
    @(posedge pclk);
    strength_value <= 7'h55;
    @(posedge pclk);
    strength_valid <= 1'h0;
    rd_chk("sample", `OFF_STRENGTH_SAMPLE, 32'h2a);
    rd_chk("idle", `OFF_RADIO_STATUS, 32'h0);
    apb(1'h1, `OFF_TASK_STRENGTH_SAMPLE_START, 32'h1);
    apb(1'h1, `OFF_TASK_STRENGTH_SAMPLE_STOP, 32'h1);
    strength_valid <= 1'h1;
    strength_value <= 7'h11;
    rd_chk("stopped", `OFF_RADIO_STATUS, 32'h0);
    rd_chk("sample kept", `OFF_STRENGTH_SAMPLE, 32'h2a);
    strength_valid <= 1'h0;
  endtask
  // ticks counted only between start and stop
  task test_counter;
    apb(1'h1, `OFF_TASK_BIT_COUNTER_START, 32'h1);
    ticks(5);
    rd_chk("counter run", `OFF_RADIO_STATUS, 32'h10);
    apb(1'h1, `OFF_TASK_BIT_COUNTER_STOP, 32'h1);
    ticks(3);
    rd_chk("bit count", `OFF_BIT_COUNT, 32'h5);
    rd_chk("counter halted", `OFF_RADIO_STATUS, 32'h0);
  endtask
  // clock enable low freezes strobe and counter
  task test_freeze;
    apb(1'h1, `OFF_TASK_BIT_COUNTER_START, 32'h1);
    ce <= 1'h0;
    ticks(4);
    chk("frozen strobe", 32'h1, {31'h0, bit_counter_start_pulse});
    ce <= 1'h1;
    ticks(2);
    apb(1'h1, `OFF_TASK_BIT_COUNTER_STOP, 32'h1);
    rd_chk("frozen count", `OFF_BIT_COUNT, 32'h2);
  endtask
  // address event, irq raise, mask and clear, unmapped access
  task test_events;
    apb(1'h1, `OFF_INT_MASK, 32'h2);
    address_done_in <= 1'h1;
    repeat (8) @(posedge pclk);
    rd_chk("address event", `OFF_EVENT_ADDRESS_DONE, 32'h1);
    rd_chk("int status", `OFF_INT_STATUS, 32'h3);
    chk("irq raised", 32'h1, {31'h0, irq});
    apb(1'h1, `OFF_INT_STATUS, 32'h2);
    rd_chk("int status cleared", `OFF_INT_STATUS, 32'h1);
    chk("irq cleared", 32'h0, {31'h0, irq});
    apb(1'h1, `OFF_EVENT_ADDRESS_DONE, 32'h0);
    rd_chk("address event cleared", `OFF_EVENT_ADDRESS_DONE, 32'h0);
    apb(1'h0, 12'h200, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
  endtask
  // counts and verdict, then stop
  task print_verdict;
    $display("comparisons %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    test_reset;
    test_strobes;
    test_state;
    test_strength;
    test_counter;
    test_freeze;
    test_events;
    print_verdict;
  end
  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    print_verdict;
  end
endmodule
